// file: hdl/rclw_top.sv
// reset cause recording, low-voltage reset/interrupt and periodic wakeup timer
//
// What this block does
// - low supply with reset enable forces reset
// - low-voltage reset holds until supply recovers
// - detector and irq enable, reset enable off: set flag, interrupt
// - wake timer counts 1 kHz or external clock
// - wake timer runs in run, wait, stop
// - wake control: flag, acknowledge, 3-bit interval
// - wake interrupt gated by its enable
// - interval zero disables wake, no interrupts
// - debug forced reset clears all cause bits
// - cause register write clears watchdog, keeps contents
// - cause register 8-bit read-only fixed layout
// - cause bits follow sources active at entry
// - low reset pin sets pin cause
// - watchdog timeout resets unless watchdog disabled
// - illegal, disallowed stop or halt opcode resets
// - unimplemented address access resets
// - detector on when enabled, in stop only with stop enable
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rclw_top
	import rclw_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// pins and analog outputs, asynchronous
	input wire logic ext_reset_pin_n,
	input wire logic lowv_below_trip,
	input wire logic osc_1khz,
	input wire logic ext_ref_clk,
	// same-clock inputs from the core and system options
	input wire logic stop_mode,
	input wire logic watchdog_timeout_flag,
	input wire logic watchdog_enable,
	input wire rclw_opcode_t opcode_check,
	input wire logic stop_permit,
	input wire logic debug_mode_enable,
	input wire logic bad_address_flag,
	input wire logic debug_forced_reset,
	input wire logic ext_ref_clock_enable,
	input wire logic ext_ref_stop_enable,
	// outputs
	output logic system_reset,
	output logic watchdog_clear,
	output logic lowv_detector_on,
	output logic irq
);

	localparam int SYNC_W = 4;

	logic [SYNC_W-1:0] sync_bits;
	logic pin_low;
	logic lowv_low;
	logic osc_level;
	logic ext_level;

	rclw_sync #(
		.WIDTH(SYNC_W),
		// idle levels: pin high, supply fine, tick sources low, so no false edge after reset
		.RST_VALUE(4'h8)
	) u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.ce(ce),
		.async_in({ext_reset_pin_n, lowv_below_trip, osc_1khz, ext_ref_clk}),
		.sync_out(sync_bits)
	);

	assign pin_low = !sync_bits[3];
	assign lowv_low = sync_bits[2];
	assign osc_level = sync_bits[1];
	assign ext_level = sync_bits[0];

	// register state
	logic [7:0] cause_reg;
	logic lowv_event_flag_reg;
	logic lowv_irq_enable_reg;
	logic lowv_reset_enable_reg;
	logic lowv_detect_enable_reg;
	logic lowv_stop_enable_reg;
	logic wake_flag_reg;
	logic periodic_clock_select_reg;
	logic periodic_irq_enable_reg;
	logic [RCLW_WK_INTERVAL_W-1:0] periodic_interval_select_reg;
	logic [RCLW_IRQ_W-1:0] irq_status_reg;
	logic [RCLW_IRQ_W-1:0] irq_mask_reg;
	rclw_state_t state_reg;

	// bus handshake
	logic req;
	logic take;
	logic wr_take;
	assign req = avs_read || avs_write;
	assign take = req && !avs_waitrequest;
	assign wr_take = take && avs_write;

	function automatic logic at(input logic [4:0] ofs);
		at = wr_take && (avs_address == ofs);
	endfunction

	function automatic logic [9:0] wake_period(input logic [2:0] sel);
		case (sel)
			3'h1: wake_period = RCLW_PERIOD_1;
			3'h2: wake_period = RCLW_PERIOD_2;
			3'h3: wake_period = RCLW_PERIOD_3;
			3'h4: wake_period = RCLW_PERIOD_4;
			3'h5: wake_period = RCLW_PERIOD_5;
			3'h6: wake_period = RCLW_PERIOD_6;
			3'h7: wake_period = RCLW_PERIOD_7;
			default: wake_period = 10'h000;
		endcase
	endfunction

	// one wait state: request seen, answer on the next edge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			avs_waitrequest <= 1'b1;
		end else if (ce) begin
			avs_waitrequest <= !(req && avs_waitrequest);
		end
	end

	// low-voltage detector gating
	logic detector_on_now;
	assign detector_on_now = lowv_detect_enable_reg && (!stop_mode || lowv_stop_enable_reg);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lowv_detector_on <= RCLW_PW_DETECT_ENABLE_RST;
		end else if (ce) begin
			lowv_detector_on <= detector_on_now;
		end
	end

	logic lowv_active;
	assign lowv_active = detector_on_now && lowv_low;

	// reset sources this cycle
	rclw_src_t src;
	always_comb begin
		src.pin = pin_low;
		src.watchdog = watchdog_timeout_flag && watchdog_enable;
		src.bad_opcode = opcode_check.unimplemented
			|| (opcode_check.stop_exec && !stop_permit)
			|| (opcode_check.debug_halt_instruction && !debug_mode_enable);
		src.bad_address = bad_address_flag;
		src.lowv = lowv_active && lowv_reset_enable_reg;
		src.debug = debug_forced_reset;
	end

	logic any_src;
	assign any_src = |src;

	// sources that keep the system in reset while present
	logic hold_src;
	assign hold_src = pin_low || (lowv_reset_enable_reg && lowv_active);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= RCLW_ST_HOLD;
		end else if (ce) begin
			case (state_reg)
				RCLW_ST_RUN: begin
					if (any_src) begin
						state_reg <= RCLW_ST_HOLD;
					end
				end
				RCLW_ST_HOLD: begin
					if (!hold_src) begin
						state_reg <= RCLW_ST_RUN;
					end
				end
				default: state_reg <= RCLW_ST_HOLD;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			system_reset <= 1'b1;
		end else if (ce) begin
			case (state_reg)
				RCLW_ST_RUN: system_reset <= any_src;
				RCLW_ST_HOLD: system_reset <= hold_src;
				default: system_reset <= 1'b1;
			endcase
		end
	end

	// cause capture at reset entry; power-on value on nrst
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cause_reg <= RCLW_CAUSE_POR_VALUE;
		end else if (ce && state_reg == RCLW_ST_RUN && any_src) begin
			if (src.debug) begin
				cause_reg <= 8'h00;
			end else begin
				cause_reg[RCLW_CS_POWER_ON] <= src.lowv && cause_reg[RCLW_CS_POWER_ON];
				cause_reg[RCLW_CS_PIN] <= src.pin;
				cause_reg[RCLW_CS_WATCHDOG] <= src.watchdog;
				cause_reg[RCLW_CS_BAD_OPCODE] <= src.bad_opcode;
				cause_reg[RCLW_CS_BAD_ADDRESS] <= src.bad_address;
				cause_reg[2] <= 1'b0;
				cause_reg[RCLW_CS_LOWV] <= src.lowv;
				cause_reg[0] <= 1'b0;
			end
		end
	end

	// any write to the cause address pulses the watchdog clear
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			watchdog_clear <= 1'b0;
		end else if (ce) begin
			watchdog_clear <= at(RCLW_OFS_CAUSE);
		end
	end

	// power management control
	logic lowv_event;
	assign lowv_event = lowv_active && lowv_irq_enable_reg && !lowv_reset_enable_reg;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lowv_irq_enable_reg <= RCLW_PW_IRQ_ENABLE_RST;
			lowv_reset_enable_reg <= RCLW_PW_RESET_ENABLE_RST;
			lowv_detect_enable_reg <= RCLW_PW_DETECT_ENABLE_RST;
			lowv_stop_enable_reg <= RCLW_PW_STOP_ENABLE_RST;
		end else if (ce && at(RCLW_OFS_PWR)) begin
			lowv_irq_enable_reg <= avs_writedata[RCLW_PW_IRQ_ENABLE];
			lowv_reset_enable_reg <= avs_writedata[RCLW_PW_RESET_ENABLE];
			lowv_detect_enable_reg <= avs_writedata[RCLW_PW_DETECT_ENABLE];
			lowv_stop_enable_reg <= avs_writedata[RCLW_PW_STOP_ENABLE];
		end
	end

	// set wins over acknowledge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lowv_event_flag_reg <= 1'b0;
		end else if (ce) begin
			if (lowv_event) begin
				lowv_event_flag_reg <= 1'b1;
			end else if (at(RCLW_OFS_PWR) && avs_writedata[RCLW_PW_ACK]) begin
				lowv_event_flag_reg <= 1'b0;
			end
		end
	end

	// periodic wake control
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			periodic_clock_select_reg <= 1'b0;
			periodic_irq_enable_reg <= 1'b0;
			periodic_interval_select_reg <= '0;
		end else if (ce && at(RCLW_OFS_WAKE)) begin
			periodic_clock_select_reg <= avs_writedata[RCLW_WK_CLOCK_SELECT];
			periodic_irq_enable_reg <= avs_writedata[RCLW_WK_IRQ_ENABLE];
			periodic_interval_select_reg <=
				avs_writedata[RCLW_WK_INTERVAL_LSB +: RCLW_WK_INTERVAL_W];
		end
	end

	// rising edges of the two tick sources, taken from synchronised levels
	logic osc_prev_reg;
	logic ext_prev_reg;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			osc_prev_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
		end else if (ce) begin
			osc_prev_reg <= osc_level;
			ext_prev_reg <= ext_level;
		end
	end

	// external ticks count only while software keeps the reference enabled
	logic ext_allowed;
	assign ext_allowed = ext_ref_clock_enable && (!stop_mode || ext_ref_stop_enable);

	logic tick;
	assign tick = periodic_clock_select_reg
		? (ext_level && !ext_prev_reg && ext_allowed)
		: (osc_level && !osc_prev_reg);

	logic wake_off;
	logic [RCLW_WAKE_CNT_W-1:0] wake_cnt_reg;
	logic wake_event;
	assign wake_off = (periodic_interval_select_reg == '0);
	assign wake_event = !wake_off && tick
		&& (wake_cnt_reg >= wake_period(periodic_interval_select_reg) - 10'h001);

	// counter is not gated by stop or wait mode
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wake_cnt_reg <= '0;
		end else if (ce) begin
			if (wake_off || at(RCLW_OFS_WAKE)) begin
				wake_cnt_reg <= '0;
			end else if (wake_event) begin
				wake_cnt_reg <= '0;
			end else if (tick) begin
				wake_cnt_reg <= wake_cnt_reg + 10'h001;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wake_flag_reg <= 1'b0;
		end else if (ce) begin
			if (wake_event) begin
				wake_flag_reg <= 1'b1;
			end else if (at(RCLW_OFS_WAKE) && avs_writedata[RCLW_WK_ACK]) begin
				wake_flag_reg <= 1'b0;
			end
		end
	end

	// sticky interrupt status, write one to clear, set wins
	logic [RCLW_IRQ_W-1:0] irq_set;
	always_comb begin
		irq_set = '0;
		irq_set[RCLW_IRQ_LOWV] = lowv_event;
		irq_set[RCLW_IRQ_WAKE] = wake_event && periodic_irq_enable_reg;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_status_reg <= '0;
		end else if (ce) begin
			if (at(RCLW_OFS_IRQ_STAT)) begin
				irq_status_reg <= (irq_status_reg & ~avs_writedata[RCLW_IRQ_W-1:0]) | irq_set;
			end else begin
				irq_status_reg <= irq_status_reg | irq_set;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_mask_reg <= '0;
		end else if (ce && at(RCLW_OFS_IRQ_MASK)) begin
			irq_mask_reg <= avs_writedata[RCLW_IRQ_W-1:0];
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |((irq_status_reg | irq_set) & irq_mask_reg);
		end
	end

	// read data, registered as the wait state ends
	logic [31:0] rd_next;
	always_comb begin
		rd_next = 32'h0000_0000;
		if (avs_address == RCLW_OFS_CAUSE) begin
			rd_next[7:0] = cause_reg;
		end else if (avs_address == RCLW_OFS_PWR) begin
			rd_next[RCLW_PW_EVENT_FLAG] = lowv_event_flag_reg;
			rd_next[RCLW_PW_IRQ_ENABLE] = lowv_irq_enable_reg;
			rd_next[RCLW_PW_RESET_ENABLE] = lowv_reset_enable_reg;
			rd_next[RCLW_PW_DETECT_ENABLE] = lowv_detect_enable_reg;
			rd_next[RCLW_PW_STOP_ENABLE] = lowv_stop_enable_reg;
		end else if (avs_address == RCLW_OFS_WAKE) begin
			rd_next[RCLW_WK_EVENT_FLAG] = wake_flag_reg;
			rd_next[RCLW_WK_CLOCK_SELECT] = periodic_clock_select_reg;
			rd_next[RCLW_WK_IRQ_ENABLE] = periodic_irq_enable_reg;
			rd_next[RCLW_WK_INTERVAL_LSB +: RCLW_WK_INTERVAL_W] = periodic_interval_select_reg;
		end else if (avs_address == RCLW_OFS_IRQ_STAT) begin
			rd_next[RCLW_IRQ_W-1:0] = irq_status_reg;
		end else if (avs_address == RCLW_OFS_IRQ_MASK) begin
			rd_next[RCLW_IRQ_W-1:0] = irq_mask_reg;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (ce && avs_read && avs_waitrequest) begin
			avs_readdata <= rd_next;
		end
	end

endmodule
`default_nettype wire

// file: hdl/rclw_pkg.sv
// constants, register map and carrier types for the reset cause / low-voltage / periodic wake block
package rclw_pkg;

	// register byte offsets on the avalon slave
	localparam logic [4:0] RCLW_OFS_CAUSE = 5'h00;
	localparam logic [4:0] RCLW_OFS_PWR = 5'h04;
	localparam logic [4:0] RCLW_OFS_WAKE = 5'h08;
	localparam logic [4:0] RCLW_OFS_IRQ_STAT = 5'h0C;
	localparam logic [4:0] RCLW_OFS_IRQ_MASK = 5'h10;

	// reset cause status bit positions
	localparam int RCLW_CS_POWER_ON = 7;
	localparam int RCLW_CS_PIN = 6;
	localparam int RCLW_CS_WATCHDOG = 5;
	localparam int RCLW_CS_BAD_OPCODE = 4;
	localparam int RCLW_CS_BAD_ADDRESS = 3;
	localparam int RCLW_CS_LOWV = 1;
	localparam logic [7:0] RCLW_CAUSE_POR_VALUE = 8'h82;

	// power management control bit positions
	localparam int RCLW_PW_EVENT_FLAG = 7;
	localparam int RCLW_PW_ACK = 6;
	localparam int RCLW_PW_IRQ_ENABLE = 5;
	localparam int RCLW_PW_RESET_ENABLE = 4;
	localparam int RCLW_PW_DETECT_ENABLE = 3;
	localparam int RCLW_PW_STOP_ENABLE = 2;
	localparam logic RCLW_PW_IRQ_ENABLE_RST = 1'b0;
	localparam logic RCLW_PW_RESET_ENABLE_RST = 1'b1;
	localparam logic RCLW_PW_DETECT_ENABLE_RST = 1'b1;
	localparam logic RCLW_PW_STOP_ENABLE_RST = 1'b0;

	// periodic wake control bit positions
	localparam int RCLW_WK_EVENT_FLAG = 7;
	localparam int RCLW_WK_ACK = 6;
	localparam int RCLW_WK_CLOCK_SELECT = 5;
	localparam int RCLW_WK_IRQ_ENABLE = 4;
	localparam int RCLW_WK_INTERVAL_LSB = 0;
	localparam int RCLW_WK_INTERVAL_W = 3;

	// interrupt status / mask bit positions
	localparam int RCLW_IRQ_LOWV = 0;
	localparam int RCLW_IRQ_WAKE = 1;
	localparam int RCLW_IRQ_W = 2;

	// periodic wake periods in source clock ticks, interval codes 1..7
	localparam int RCLW_WAKE_CNT_W = 10;
	localparam logic [9:0] RCLW_PERIOD_1 = 10'h008;
	localparam logic [9:0] RCLW_PERIOD_2 = 10'h020;
	localparam logic [9:0] RCLW_PERIOD_3 = 10'h040;
	localparam logic [9:0] RCLW_PERIOD_4 = 10'h080;
	localparam logic [9:0] RCLW_PERIOD_5 = 10'h100;
	localparam logic [9:0] RCLW_PERIOD_6 = 10'h200;
	localparam logic [9:0] RCLW_PERIOD_7 = 10'h3FF;

	// reset sources seen in one cycle
	typedef struct packed {
		logic pin;
		logic watchdog;
		logic bad_opcode;
		logic bad_address;
		logic lowv;
		logic debug;
	} rclw_src_t;

	// opcode checks reported by the core
	typedef struct packed {
		logic unimplemented;
		logic stop_exec;
		logic debug_halt_instruction;
	} rclw_opcode_t;

	typedef enum logic {
		RCLW_ST_RUN,
		RCLW_ST_HOLD
	} rclw_state_t;

endpackage

// file: hdl/rclw_sync.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
`default_nettype none
module rclw_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	initial begin
		if (WIDTH < 1) $error("rclw_sync: WIDTH must be positive");
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= RST_VALUE;
			sync_out <= RST_VALUE;
		end else if (ce) begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// file: testbench/rclw_top_properties.sv
// concurrent checks on the ports of the reset cause, low-voltage and wake block
`timescale 1ns/10ps
`default_nettype none
module rclw_top_properties
	import rclw_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic ext_reset_pin_n,
	input wire logic watchdog_timeout_flag,
	input wire logic watchdog_enable,
	input wire rclw_opcode_t opcode_check,
	input wire logic stop_permit,
	input wire logic bad_address_flag,
	input wire logic debug_forced_reset,
	input wire logic system_reset,
	input wire logic watchdog_clear,
	input wire logic irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	logic run;
	assign run = ce && !system_reset;
	property p_wdt; run && watchdog_timeout_flag && watchdog_enable |=> system_reset; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog timeout gave no reset");
	property p_opc; run && opcode_check.unimplemented |=> system_reset; endproperty
	a_opc: assert property (p_opc) else $error("bad opcode gave no reset");
	property p_stop; run && opcode_check.stop_exec && !stop_permit |=> system_reset; endproperty
	a_stop: assert property (p_stop) else $error("forbidden stop gave no reset");
	property p_adr; run && bad_address_flag |=> system_reset; endproperty
	a_adr: assert property (p_adr) else $error("bad address gave no reset");
	property p_dbg; run && debug_forced_reset |=> system_reset; endproperty
	a_dbg: assert property (p_dbg) else $error("debug reset not taken");
	property p_pin; (ce && !ext_reset_pin_n) [*4] |-> system_reset; endproperty
	a_pin: assert property (p_pin) else $error("low reset pin not holding reset");
	property p_wclr;
		ce && avs_write && !avs_waitrequest && avs_address == RCLW_OFS_CAUSE
			|=> watchdog_clear ##1 !watchdog_clear;
	endproperty
	a_wclr: assert property (p_wclr) else $error("cause write gave no clear pulse");
	property p_cause;
		avs_read && !avs_waitrequest && avs_address == RCLW_OFS_CAUSE
			|-> avs_readdata[31:8] == 24'h0 && !avs_readdata[2] && !avs_readdata[0];
	endproperty
	a_cause: assert property (p_cause) else $error("cause read has stray bits");
	property p_wait;
		ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer timing wrong");
	c_wclr: cover property (watchdog_clear);
	c_irq: cover property ($rose(irq));
	c_rel: cover property ($fell(system_reset));
endmodule
bind rclw_top rclw_top_properties u_props (.mclk(mclk), .nrst(nrst), .ce(ce),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.ext_reset_pin_n(ext_reset_pin_n), .watchdog_timeout_flag(watchdog_timeout_flag),
	.watchdog_enable(watchdog_enable), .opcode_check(opcode_check), .stop_permit(stop_permit),
	.bad_address_flag(bad_address_flag), .debug_forced_reset(debug_forced_reset),
	.system_reset(system_reset), .watchdog_clear(watchdog_clear), .irq(irq));
`default_nettype wire

// file: testbench/tb_rclw_top.sv
// self-checking bench for the reset cause, low-voltage and wake block
`timescale 1ns/10ps
`default_nettype none
module tb_rclw_top
	import rclw_pkg::*;
;
	logic mclk = 0, nrst = 0, ce = 1, avs_read = 0, avs_write = 0;
	logic [4:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata;
	logic avs_waitrequest, system_reset, watchdog_clear, lowv_detector_on, irq;
	logic ext_reset_pin_n = 1, lowv_below_trip = 0, osc_1khz = 0, ext_ref_clk = 0;
	logic stop_mode = 0, watchdog_timeout_flag = 0, watchdog_enable = 1, stop_permit = 0;
	logic debug_mode_enable = 0, bad_address_flag = 0, debug_forced_reset = 0;
	logic ext_ref_clock_enable = 1, ext_ref_stop_enable = 0;
	rclw_opcode_t opcode_check = '0;
	integer seed = 32'h1253;
	logic [31:0] q[$];
	logic [7:0] tk = 0;
	logic [7:0] cz[7] = '{8'h20, 8'h10, 8'h10, 8'h10, 8'h08, 8'h00, 8'h40};
	logic [9:0] pz[8] = '{10'h0, RCLW_PERIOD_1, RCLW_PERIOD_2, RCLW_PERIOD_3, RCLW_PERIOD_4,
		RCLW_PERIOD_5, RCLW_PERIOD_6, RCLW_PERIOD_7};
	int bad_count = 0, n_checks = 0, cyc = 0;

	rclw_top dut (.mclk(mclk), .nrst(nrst), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ext_reset_pin_n(ext_reset_pin_n), .lowv_below_trip(lowv_below_trip),
		.osc_1khz(osc_1khz), .ext_ref_clk(ext_ref_clk), .stop_mode(stop_mode),
		.watchdog_timeout_flag(watchdog_timeout_flag), .watchdog_enable(watchdog_enable),
		.opcode_check(opcode_check), .stop_permit(stop_permit),
		.debug_mode_enable(debug_mode_enable), .bad_address_flag(bad_address_flag),
		.debug_forced_reset(debug_forced_reset), .ext_ref_clock_enable(ext_ref_clock_enable),
		.ext_ref_stop_enable(ext_ref_stop_enable), .system_reset(system_reset),
		.watchdog_clear(watchdog_clear), .lowv_detector_on(lowv_detector_on), .irq(irq));

	always #5 mclk = ~mclk;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR at %0t: saw %h, wanted %h", $time, got, exp);
		end
	endtask

	task wrap_up;
		$display("checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// slow tick sources plus the run ceiling
	always @(posedge mclk) begin
		tk <= tk + 8'h01;
		if (tk[2:0] == 3'h7) osc_1khz <= ~osc_1khz;
		if (tk[1:0] == 2'h3) ext_ref_clk <= ~ext_ref_clk;
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			wrap_up;
		end
	end

	// read answers are compared against the oldest noted expectation
	always @(posedge mclk)
		if (avs_read && avs_waitrequest === 1'b0 && q.size() > 0) check(avs_readdata, q.pop_front());

	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= {24'($random(seed)), d};
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_read <= 0;
		avs_write <= 0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		q.push_back({24'h0, e});
		bus(0, a, 8'h00);
	endtask

	// fire one reset source, then read back the recorded cause
	task automatic hit(input int k, input logic r, input logic [7:0] c);
		@(posedge mclk);
		case (k)
			0: watchdog_timeout_flag <= 1;
			1: opcode_check.unimplemented <= 1;
			2: opcode_check.stop_exec <= 1;
			3: opcode_check.debug_halt_instruction <= 1;
			4: bad_address_flag <= 1;
			5: debug_forced_reset <= 1;
			default: ext_reset_pin_n <= 0;
		endcase
		repeat (k == 6 ? 6 : 1) @(posedge mclk);
		{watchdog_timeout_flag, bad_address_flag, debug_forced_reset} <= '0;
		opcode_check <= '0;
		ext_reset_pin_n <= 1;
		@(posedge mclk);
		check(32'(system_reset), 32'(r));
		while (system_reset !== 1'b0) @(posedge mclk);
		rd(RCLW_OFS_CAUSE, c);
	endtask

	initial begin
		int n;
		int t;
		logic [5:0] w;
		repeat (16) @(posedge mclk);
		nrst <= 1;
		while (system_reset !== 1'b0) @(posedge mclk);
		rd(RCLW_OFS_CAUSE, RCLW_CAUSE_POR_VALUE);
		rd(RCLW_OFS_PWR, 8'h18);
		bus(1, RCLW_OFS_CAUSE, 8'($random(seed)));
		rd(RCLW_OFS_CAUSE, 8'h82);
		bus(1, 5'h14, 8'hFF);
		rd(5'h14, 8'h00);
		for (int k = 0; k < 7; k++) hit(k, 1, cz[k]);
		watchdog_enable <= 0;
		stop_permit <= 1;
		debug_mode_enable <= 1;
		for (int k = 0; k < 4; k++)
			if (k != 1) hit(k, 0, 8'h40);
		lowv_below_trip <= 1;
		repeat (30) @(posedge mclk);
		check(32'(system_reset), 1);
		lowv_below_trip <= 0;
		while (system_reset !== 1'b0) @(posedge mclk);
		rd(RCLW_OFS_CAUSE, 8'h02);
		bus(1, RCLW_OFS_PWR, 8'h28);
		for (int m = 1; m >= 0; m--) begin
			bus(1, RCLW_OFS_IRQ_MASK, m ? 8'h03 : 8'h00);
			lowv_below_trip <= 1;
			repeat (8) @(posedge mclk);
			lowv_below_trip <= 0;
			check(32'(irq), 32'(m));
			rd(RCLW_OFS_PWR, 8'hA8);
			rd(RCLW_OFS_IRQ_STAT, 8'h01);
			bus(1, RCLW_OFS_PWR, 8'h68);
			bus(1, RCLW_OFS_IRQ_STAT, 8'h01);
			rd(RCLW_OFS_PWR, 8'h28);
		end
		check(32'(irq), 0);
		stop_mode <= 1;
		ext_ref_stop_enable <= 1;
		bus(1, RCLW_OFS_IRQ_MASK, 8'h03);
		check(32'(lowv_detector_on), 0);
		for (int c = 1; c < 8; c++) begin
			w = {1'(c > 1), 2'b10, 3'(c)};
			t = c > 1 ? 8 : 16;
			bus(1, RCLW_OFS_WAKE, {2'b00, w});
			n = 0;
			while (irq !== 1'b1 && n < 9000) begin
				@(posedge mclk);
				n++;
			end
			check(32'(n >= (pz[c] - 2) * t && n <= (pz[c] + 1) * t), 1);
			rd(RCLW_OFS_WAKE, {2'b10, w});
			bus(1, RCLW_OFS_WAKE, {2'b01, w});
			bus(1, RCLW_OFS_IRQ_STAT, 8'h02);
			rd(RCLW_OFS_WAKE, {2'b00, w});
		end
		stop_mode <= 0;
		bus(1, RCLW_OFS_WAKE, 8'h10);
		repeat (300) @(posedge mclk);
		check(32'(irq), 0);
		rd(RCLW_OFS_WAKE, 8'h10);
		bus(1, RCLW_OFS_WAKE, 8'h01);
		repeat (200) @(posedge mclk);
		check(32'(irq), 0);
		rd(RCLW_OFS_WAKE, 8'h81);
		rd(RCLW_OFS_IRQ_STAT, 8'h00);
		check(32'(lowv_detector_on), 1);
		wrap_up;
	end
endmodule
`default_nettype wire
